//--- rtl/sscc_pkg.sv
package sscc_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int SSCC_ADDR_W = 17;
	localparam int SSCC_DATA_W = 18;
	localparam int SSCC_BYTES = 2;
	localparam int SSCC_BURST_W = 2;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int SSCC_CLK_PERIOD_NS = 10;
	localparam int SSCC_SLEEP_ENTRY_LATENCY_NS = 20;
	localparam int SSCC_SLEEP_EXIT_RECOVERY_NS = 20;
	// longest times round down to whole cycles
	localparam int SSCC_SLEEP_ENTRY_CYC = SSCC_SLEEP_ENTRY_LATENCY_NS / SSCC_CLK_PERIOD_NS;
	localparam int SSCC_SLEEP_EXIT_CYC = SSCC_SLEEP_EXIT_RECOVERY_NS / SSCC_CLK_PERIOD_NS;
	// synchroniser depth must fit both entry and exit latency
	localparam int SSCC_SYNC_N = (SSCC_SLEEP_ENTRY_CYC < SSCC_SLEEP_EXIT_CYC) ?
		SSCC_SLEEP_ENTRY_CYC : SSCC_SLEEP_EXIT_CYC;

	// ----------------------------------------
	// burst order pin levels
	// ----------------------------------------
	localparam logic SSCC_ORDER_LINEAR = 1'b0;
	localparam logic SSCC_ORDER_INTERLEAVED = 1'b1;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic {
		SSCC_PWR_ACTIVE,
		SSCC_PWR_SNOOZE
	} sscc_pwr_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic interleaved;
		logic [SSCC_BURST_W-1:0] base;
		logic [SSCC_BURST_W-1:0] cnt;
		logic [SSCC_ADDR_W-1:0] addr;
		logic [SSCC_BYTES-1:0] be;
	} sscc_cmd_s;

	typedef struct packed {
		logic valid;
		logic [SSCC_ADDR_W-1:0] addr;
		logic [SSCC_DATA_W-1:0] data;
		logic [SSCC_BYTES-1:0] be;
	} sscc_pend_s;

	localparam sscc_cmd_s SSCC_CMD_RST = '0;
	localparam sscc_pend_s SSCC_PEND_RST = '0;
	localparam logic [SSCC_DATA_W-1:0] SSCC_DATA_RST = '0;
	localparam logic SSCC_OE_RST = 1'b0;

endpackage

//--- rtl/sscc_burst_seq.sv
`timescale 1ns/1ps
`default_nettype none

module sscc_burst_seq #(
	parameter int W = 2
) (
	input wire logic [W-1:0] base,
	input wire logic [W-1:0] step,
	input wire logic interleaved,
	output logic [W-1:0] offset
);

	// ----------------------------------------
	// burst offset: wraps within the burst
	// ----------------------------------------
	always_comb begin
		if (interleaved) begin
			offset = base ^ step;
		end else begin
			offset = W'(base + step);
		end
	end

endmodule

`default_nettype wire

//--- rtl/sscc_core.sv
`timescale 1ns/1ps
`default_nettype none

module sscc_core
	import sscc_pkg::*;
#(
	parameter int DEPTH = 2 ** sscc_pkg::SSCC_ADDR_W
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic sleep_request,
	input wire logic cycle_enable_n,
	input wire logic advance_load_n,
	input wire logic select_first_n,
	input wire logic select_second_n,
	input wire logic select_high,
	input wire logic write_n,
	input wire logic [sscc_pkg::SSCC_BYTES-1:0] byte_write_n,
	input wire logic burst_order,
	input wire logic out_enable_n,
	input wire logic [sscc_pkg::SSCC_ADDR_W-1:0] addr,
	input wire logic [sscc_pkg::SSCC_DATA_W-1:0] dq_in,
	output logic [sscc_pkg::SSCC_DATA_W-1:0] dq_out,
	output logic dq_oe
);
	import sscc_pkg::*;

	localparam int BW = SSCC_DATA_W / SSCC_BYTES;

	// ----------------------------------------
	// sleep synchroniser and power state
	// ----------------------------------------
	logic [SSCC_SYNC_N-1:0] sync_q;
	logic [SSCC_SYNC_N-1:0] sync_d;
	sscc_pwr_e pwr_st;

	always_comb begin
		sync_d = {sync_q[SSCC_SYNC_N-2:0], sleep_request};
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sync_q <= '0;
		end else if (clk_en) begin
			sync_q <= sync_d;
		end
	end

	// last stage is the state itself, so entry and exit take exactly the sync depth
	always_comb begin
		case (sync_q[SSCC_SYNC_N-1])
			1'b1: pwr_st = SSCC_PWR_SNOOZE;
			1'b0: pwr_st = SSCC_PWR_ACTIVE;
			default: pwr_st = SSCC_PWR_ACTIVE;
		endcase
	end

	// ----------------------------------------
	// pipeline
	// ----------------------------------------
	logic [SSCC_DATA_W-1:0] mem [DEPTH];
	sscc_cmd_s cmd_q, cmd_d, s2_q, s2_d;
	sscc_pend_s pend_q, pend_d;
	logic [SSCC_DATA_W-1:0] data_q, data_d;
	logic oe_q, oe_d;
	logic mem_we;
	logic selected;
	logic go;
	logic [SSCC_DATA_W-1:0] fwd_word;
	logic [SSCC_BURST_W-1:0] next_cnt;
	logic [SSCC_BURST_W-1:0] next_off;

	assign selected = ~select_first_n & ~select_second_n & select_high;
	assign go = clk_en & ~cycle_enable_n & (pwr_st == SSCC_PWR_ACTIVE);
	assign next_cnt = SSCC_BURST_W'(cmd_q.cnt + 1'b1);

	sscc_burst_seq #(
		.W(SSCC_BURST_W)
	) sscc_burst_seq_inst (
		.base(cmd_q.base),
		.step(next_cnt),
		.interleaved(cmd_q.interleaved),
		.offset(next_off)
	);

	// newest data wins: pending write bytes override the array
	always_comb begin
		fwd_word = mem[s2_q.addr];
		for (int b = 0; b < SSCC_BYTES; b++) begin
			if (pend_q.valid && pend_q.addr == s2_q.addr && pend_q.be[b]) begin
				fwd_word[b*BW +: BW] = pend_q.data[b*BW +: BW];
			end
		end
	end

	always_comb begin
		cmd_d = cmd_q;
		s2_d = s2_q;
		pend_d = pend_q;
		data_d = data_q;
		oe_d = oe_q;
		mem_we = 1'b0;
		if (clk_en) begin
			if (pwr_st == SSCC_PWR_SNOOZE) begin
				// in-flight commands are dropped; the pending write survives
				cmd_d.valid = 1'b0;
				s2_d.valid = 1'b0;
				oe_d = 1'b0;
			end else if (!cycle_enable_n) begin
				if (!advance_load_n) begin
					cmd_d.valid = selected;
					cmd_d.write = ~write_n;
					cmd_d.interleaved = (burst_order == SSCC_ORDER_INTERLEAVED);
					cmd_d.base = addr[SSCC_BURST_W-1:0];
					cmd_d.cnt = '0;
					cmd_d.addr = addr;
					cmd_d.be = ~byte_write_n;
				end else if (cmd_q.valid) begin
					cmd_d.cnt = next_cnt;
					cmd_d.addr = {cmd_q.addr[SSCC_ADDR_W-1:SSCC_BURST_W], next_off};
				end
				s2_d = cmd_q;
				oe_d = s2_q.valid & ~s2_q.write;
				if (s2_q.valid && !s2_q.write) begin
					data_d = fwd_word;
				end
				if (s2_q.valid && s2_q.write) begin
					// late write: older pending data goes to the array now
					mem_we = pend_q.valid;
					pend_d.valid = 1'b1;
					pend_d.addr = s2_q.addr;
					pend_d.data = dq_in;
					pend_d.be = s2_q.be;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cmd_q <= SSCC_CMD_RST;
			s2_q <= SSCC_CMD_RST;
			pend_q <= SSCC_PEND_RST;
			data_q <= SSCC_DATA_RST;
			oe_q <= SSCC_OE_RST;
		end else begin
			cmd_q <= cmd_d;
			s2_q <= s2_d;
			pend_q <= pend_d;
			data_q <= data_d;
			oe_q <= oe_d;
		end
	end

	// array has no reset, as a real core
	always_ff @(posedge core_clk) begin
		if (mem_we) begin
			for (int b = 0; b < SSCC_BYTES; b++) begin
				if (pend_q.be[b]) begin
					mem[pend_q.addr][b*BW +: BW] <= pend_q.data[b*BW +: BW];
				end
			end
		end
	end

	// ----------------------------------------
	// data pins
	// ----------------------------------------
	assign dq_out = data_q;
	// raw pin gates the drive so the bus floats at once, before the sync settles
	assign dq_oe = oe_q & ~out_enable_n & ~sleep_request & (pwr_st == SSCC_PWR_ACTIVE);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sleep_float_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		sleep_request |-> !dq_oe)
		else $error("data driven while sleep is high");

	snooze_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
		(pwr_st == SSCC_PWR_SNOOZE) && $past(clk_en) && $past(clk_en, 2) |-> $past(sleep_request, 2))
		else $error("snooze without sleep request");

	sleep_entry_a: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
		sleep_request [*2] |=> (pwr_st == SSCC_PWR_SNOOZE) ##1 (!cmd_q.valid && !s2_q.valid))
		else $error("snooze entry too slow");

	sleep_exit_a: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
		!sleep_request [*2] |=> (pwr_st == SSCC_PWR_ACTIVE))
		else $error("snooze exit too slow");

	burst_order_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		go && advance_load_n && cmd_q.valid |=>
		cmd_q.addr[SSCC_BURST_W-1:0] == ($past(cmd_q.interleaved) ?
		($past(cmd_q.base) ^ $past(next_cnt)) : SSCC_BURST_W'($past(cmd_q.base) + $past(next_cnt))))
		else $error("burst offset wrong for order");

	select_decode_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		go && !advance_load_n |=> cmd_q.valid == $past(selected))
		else $error("select decode wrong");

	read_forward_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		go && s2_q.valid && !s2_q.write && pend_q.valid && pend_q.addr == s2_q.addr && (&pend_q.be)
		|=> data_q == $past(pend_q.data))
		else $error("read missed pending write data");

	stall_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && cycle_enable_n && (pwr_st == SSCC_PWR_ACTIVE)
		|-> !mem_we ##1 ($stable(cmd_q) && $stable(s2_q) && $stable(pend_q)))
		else $error("state moved or write during stall");

	direction_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		go && !advance_load_n && selected |=> cmd_q.valid && (cmd_q.write == !$past(write_n)))
		else $error("direction decode wrong");

	read_latency_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(go && cmd_q.valid && !cmd_q.write) ##1 go |=> oe_q)
		else $error("read data not on bus two edges after command");

	write_latency_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(go && cmd_q.valid && cmd_q.write) ##1 go |=> pend_q.valid && pend_q.data == $past(dq_in))
		else $error("write data not taken two edges after command");

endmodule

`default_nettype wire

//--- testbench/sscc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// memory controller model
// ----
module sscc_ctrl_model
	import sscc_pkg::*;
(
	output logic clk_en,
	output logic sleep_request,
	output logic cycle_enable_n,
	output logic advance_load_n,
	output logic select_first_n,
	output logic select_second_n,
	output logic select_high,
	output logic write_n,
	output logic [sscc_pkg::SSCC_BYTES-1:0] byte_write_n,
	output logic burst_order,
	output logic out_enable_n,
	output logic [sscc_pkg::SSCC_ADDR_W-1:0] addr,
	output logic [sscc_pkg::SSCC_DATA_W-1:0] dq_in
);
	import sscc_pkg::*;

	task automatic cmd(input logic st, c, ord, oen, input logic [2:0] sel, input logic adv, wr,
		input logic [SSCC_BYTES-1:0] be, input logic [SSCC_ADDR_W-1:0] a);
		clk_en = !(st && c);
		cycle_enable_n = st && !c;
		{select_first_n, select_second_n, select_high} = sel;
		advance_load_n = adv;
		write_n = wr;
		byte_write_n = be;
		burst_order = ord;
		out_enable_n = oen;
		addr = a;
	endtask

	// idle bus flips so stale data never looks valid
	task automatic dat(input logic v, input logic [SSCC_DATA_W-1:0] d);
		dq_in = v ? d : ~dq_in;
	endtask

	task automatic snooze(input logic v);
		sleep_request = v;
	endtask

	initial begin
		sleep_request = 1'b0;
		dq_in = '0;
		cmd(0, 0, 0, 0, 3'h0, 0, 1, '1, '0);
	end
endmodule
`default_nettype wire

//--- testbench/sscc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// snooze and cycle control bench
// ----
module sscc_core_tb;
	import sscc_pkg::*;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [17:0] d;
	} sscc_op_s;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en, sleep_request, cycle_enable_n, advance_load_n, select_first_n, select_second_n;
	logic select_high, write_n, burst_order, out_enable_n, dq_oe;
	logic [1:0] byte_write_n, bb, bn, bbe;
	logic [16:0] addr;
	logic [17:0] dq_in, dq_out;
	logic [17:0] mem [8];
	sscc_op_s p0 = '0, p1 = '0, p2 = '0, cur = '0;
	logic taken = 1'b0, asleep = 1'b0, bok = 1'b0, bwr, bord, bhi;
	logic [13:0] hi;
	int seed = 14;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	int r;

	always #5 core_clk = ~core_clk;

	sscc_ctrl_model sscc_ctrl_model_inst (.clk_en, .sleep_request, .cycle_enable_n, .advance_load_n,
		.select_first_n, .select_second_n, .select_high, .write_n, .byte_write_n, .burst_order,
		.out_enable_n, .addr, .dq_in);
	sscc_core sscc_core_inst (.core_clk, .sys_rst, .clk_en, .sleep_request, .cycle_enable_n,
		.advance_load_n, .select_first_n, .select_second_n, .select_high, .write_n, .byte_write_n,
		.burst_order, .out_enable_n, .addr, .dq_in, .dq_out, .dq_oe);

	function automatic logic [17:0] merge(input logic [17:0] o, d, input logic [1:0] be);
		return {be[1] ? o[17:9] : d[17:9], be[0] ? o[8:0] : d[8:0]};
	endfunction

	task automatic chk_data(input logic [17:0] got, exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, exp);
		chk_data({17'h0, got}, {17'h0, exp});
	endtask

	task automatic tally_and_finish;
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// one cycle: score the last taken edge, then drive the next
	task automatic tick(input logic st, c, ord, oen, input logic [2:0] sel, input logic adv, wr,
		input logic [1:0] be, input logic [2:0] lo, input logic [17:0] d);
		logic [16:0] a;
		if (taken && !asleep) begin
			p2 = p1;
			p1 = p0;
			p0 = cur;
			chk_flag(dq_oe, p2.rd & ~out_enable_n);
			if (p2.rd) chk_data(dq_out, p2.d);
		end
		cur = '0;
		if (!st && !asleep) begin
			if (!adv) begin
				bok = (sel == 3'h1);
				{bhi, bb} = lo;
				bn = 2'h0;
				bord = ord;
				bwr = ~wr;
				bbe = be;
			end else
				bn = bn + 2'h1;
			a = {hi, bhi, bord ? bb ^ bn : bb + bn};
			if (bok) begin
				cur.rd = ~bwr;
				cur.wr = bwr;
				if (bwr) mem[a[2:0]] = merge(mem[a[2:0]], d, bbe);
				cur.d = bwr ? d : mem[a[2:0]];
			end
		end
		taken = !st;
		sscc_ctrl_model_inst.cmd(st, c, ord, oen, sel, adv, wr, be, {hi, lo});
		sscc_ctrl_model_inst.dat(p1.wr, p1.d);
		@(negedge core_clk);
	endtask

	task automatic idle(input logic [2:0] lo);
		tick(0, 0, 0, 0, 3'h0, 0, 1, 2'h3, lo, 18'h0);
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			tally_and_finish();
		end
	end

	initial begin
		r = $random(seed);
		hi = r[13:0];
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		sys_rst = 1'b0;
		for (int i = 0; i < 8; i++) tick(0, 0, 0, 0, 3'h1, 0, 0, 2'h0, 3'(i), 18'($random(seed)));
		tick(0, 0, 0, 0, 3'h1, 0, 0, 2'h2, 3'h5, 18'h3ffff);
		tick(1, 0, 0, 0, 3'h1, 0, 0, 2'h0, 3'h5, 18'h0);
		tick(0, 0, 0, 0, 3'h1, 0, 1, 2'h3, 3'h5, 18'h0);
		tick(0, 0, 0, 0, 3'h1, 0, 0, 2'h1, 3'h5, 18'h15555);
		tick(0, 0, 0, 0, 3'h1, 0, 1, 2'h3, 3'h5, 18'h0);
		for (int o = 0; o < 2; o++) begin
			tick(0, 0, o[0], 0, 3'h1, 0, 1, 2'h3, 3'h5, 18'h0);
			repeat (3) tick(0, 0, 0, 0, 3'h1, 1, 1, 2'h3, 3'h0, 18'h0);
		end
		$display("test corner done");
		repeat (400) begin
			r = $random(seed);
			tick(r[2:0] == 3'h0, r[3], r[14], r[15] & r[16], r[7:6] == 2'h0 ? r[10:8] : 3'h1,
				r[11] & r[12], r[13], r[18:17], r[21:19], 18'($random(seed)));
		end
		$display("test random done");
		tick(0, 0, 0, 0, 3'h1, 0, 1, 2'h3, 3'h2, 18'h0);
		repeat (2) idle(3'h0);
		asleep = 1'b1;
		sscc_ctrl_model_inst.snooze(1'b1);
		#1;
		chk_flag(dq_oe, 1'b0);
		chk_data(dq_out, p1.d);
		for (int i = 0; i < 8; i++) begin
			tick(0, 0, 0, 0, i < 2 ? 3'h0 : 3'h1, 0, 0, 2'h0, 3'(i), 18'h0);
			chk_flag(dq_oe, 1'b0);
		end
		sscc_ctrl_model_inst.snooze(1'b0);
		repeat (2) idle(3'h0);
		asleep = 1'b0;
		bok = 1'b0;
		{p0, p1, p2} = '0;
		for (int i = 0; i < 8; i++) tick(0, 0, 0, 0, 3'h1, 0, 1, 2'h3, 3'(i), 18'h0);
		repeat (3) idle(3'h0);
		$display("test snooze done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
